// File: rtl/ccm_regs.sv
// Charger control mirror bank: four 8-bit registers behind an APB slave.
// Assumes an APB3 master on sys_clk and charger regulation flags from pins.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`include "ccm_defines.svh"

module ccm_regs
  import ccm_pkg::*;
#(
  parameter logic [31:0] REFRESH_CYCLES = `CCM_REFRESH_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Stored defaults
  input  wire ccm_nv_t     nv_defaults,
  // Gauge charge voltage control
  input  wire logic        charge_voltage_load,
  input  wire logic [5:0]  charge_voltage_value,
  // Charger regulation flags
  input  wire logic        vin_reg_pin,
  input  wire logic        iin_reg_pin,
  input  wire logic        therm_reg_pin,
  // Charger settings
  output ccm_image_t       charger_image,
  output logic      [11:0] precharge_ma,
  output logic      [11:0] termination_ma,
  output logic      [5:0]  timer_hours,
  output logic             wdog_refresh
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [11:0] addr_of(input logic [7:0] idx);
    addr_of = {2'h0, idx, 2'h0};
  endfunction : addr_of

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  function automatic logic [11:0] cur_ma(input logic [3:0] f);
    cur_ma = {1'b0, f, 7'h00} + `CCM_CUR_OFFSET_MA;
  endfunction : cur_ma

  function automatic logic [5:0] tmr_hours(input logic       en,
                                           input logic [1:0] len,
                                           input logic       dbl);
    logic [5:0] h;
    case (len)
      2'h0:    h = `CCM_TMR_H0;
      2'h1:    h = `CCM_TMR_H1;
      2'h2:    h = `CCM_TMR_H2;
      default: h = `CCM_TMR_H3;
    endcase
    if (!en) begin
      tmr_hours = 6'h00;
    end else if (dbl) begin
      tmr_hours = {h[4:0], 1'b0};
    end else begin
      tmr_hours = h;
    end
  endfunction : tmr_hours

  // ----------------------------------------
  // Field storage
  // ----------------------------------------
  logic [3:0] prechg_reg;
  logic [3:0] term_cur_reg;
  logic [5:0] charge_voltage_reg;
  logic       batlow_reg;
  logic       term_stat_reg;
  logic       tmr_en_reg;
  logic [1:0] tmr_len_reg;
  logic [7:0] irth_reg;
  logic       load_pending_reg;

  // ----------------------------------------
  // Bus state
  // ----------------------------------------
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        access;
  logic        done_wr;
  logic        hit0, hit1, hit2, hit3;
  logic        mapped;
  logic [7:0]  rd_byte;
  logic [7:0]  wr_byte;

  // ----------------------------------------
  // Synchronisers for regulation flags
  // ----------------------------------------
  logic [2:0] reg_meta_reg;
  logic [2:0] reg_sync_reg;
  logic       dbl_timer;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_meta_reg <= 3'h0;
      reg_sync_reg <= 3'h0;
    end else begin
      reg_meta_reg <= {vin_reg_pin, iin_reg_pin, therm_reg_pin};
      reg_sync_reg <= reg_meta_reg;
    end
  end
  assign dbl_timer = |reg_sync_reg;

  // ----------------------------------------
  // Register image
  // ----------------------------------------
  ccm_image_t img;
  always_comb begin
    img.precharge_term_current    = {prechg_reg, term_cur_reg};
    img.charge_voltage_control    = {charge_voltage_reg, batlow_reg, `CCM_RECHG_FIXED};
    img.termination_timer_control = {`CCM_TERM_EN_FIXED, term_stat_reg,
                                     `CCM_WDOG_SEL_FIXED, tmr_en_reg,
                                     tmr_len_reg, `CCM_TEMP_ISET_FIXED};
    img.ir_comp_thermal_control   = irth_reg;
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign hit0   = (paddr == addr_of(`CCM_IDX_PRETERM));
  assign hit1   = (paddr == addr_of(`CCM_IDX_VOLTAGE));
  assign hit2   = (paddr == addr_of(`CCM_IDX_TERMTIMER));
  assign hit3   = (paddr == addr_of(`CCM_IDX_IRTHERMAL));
  assign mapped = hit0 | hit1 | hit2 | hit3;
  always_comb begin
    rd_byte = 8'h00;
    if (hit0) begin
      rd_byte = img.precharge_term_current;
    end else if (hit1) begin
      rd_byte = img.charge_voltage_control;
    end else if (hit2) begin
      rd_byte = img.termination_timer_control;
    end else if (hit3) begin
      rd_byte = img.ir_comp_thermal_control;
    end
  end
  assign wr_byte = pwdata[7:0];

  // ----------------------------------------
  // APB handshake: one wait state, then answer
  // ----------------------------------------
  assign access  = psel && penable && !pready_reg;
  assign done_wr = psel && penable && pready_reg && pwrite && mapped;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= access;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (access) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_reg <= !mapped;
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Default load after reset release
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      load_pending_reg <= 1'b1;
    end else begin
      load_pending_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Precharge / termination current
  // ----------------------------------------
  logic [7:0] preterm_w;
  assign preterm_w = merge(img.precharge_term_current, wr_byte, `CCM_WMASK_PRETERM);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prechg_reg   <= 4'h0;
      term_cur_reg <= 4'h0;
    end else if (load_pending_reg) begin
      prechg_reg   <= nv_defaults.precharge_current;
      term_cur_reg <= nv_defaults.termination_current;
    end else if (done_wr && hit0) begin
      prechg_reg   <= preterm_w[7:4];
      term_cur_reg <= preterm_w[3:0];
    end
  end

  // ----------------------------------------
  // Charge voltage and entry threshold
  // ----------------------------------------
  logic [7:0] volt_w;
  assign volt_w = merge(img.charge_voltage_control, wr_byte, `CCM_WMASK_VOLTAGE);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_voltage_reg <= `CCM_CHARGE_VOLTAGE_RST;
    end else if (charge_voltage_load) begin
      charge_voltage_reg <= charge_voltage_value;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      batlow_reg <= 1'b0;
    end else if (load_pending_reg) begin
      batlow_reg <= nv_defaults.fast_charge_entry_threshold;
    end else if (done_wr && hit1) begin
      batlow_reg <= volt_w[1];
    end
  end

  // ----------------------------------------
  // Termination / timer control
  // ----------------------------------------
  logic [7:0] tt_w;
  assign tt_w = merge(img.termination_timer_control, wr_byte, `CCM_WMASK_TERMTIMER);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      term_stat_reg <= `CCM_TERM_STAT_RST;
      tmr_en_reg    <= 1'b0;
      tmr_len_reg   <= 2'h0;
    end else if (load_pending_reg) begin
      term_stat_reg <= `CCM_TERM_STAT_RST;
      tmr_en_reg    <= nv_defaults.timer_enable;
      tmr_len_reg   <= nv_defaults.fast_charge_timer_length;
    end else if (done_wr && hit2) begin
      term_stat_reg <= tt_w[6];
      tmr_en_reg    <= tt_w[3];
      tmr_len_reg   <= tt_w[2:1];
    end
  end

  // ----------------------------------------
  // IR compensation / thermal regulation
  // ----------------------------------------
  logic [7:0] irth_w;
  assign irth_w = merge(img.ir_comp_thermal_control, wr_byte, `CCM_WMASK_IRTHERMAL);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irth_reg <= 8'h00;
    end else if (load_pending_reg) begin
      irth_reg <= {nv_defaults.ir_comp_resistor, nv_defaults.ir_comp_clamp,
                   nv_defaults.thermal_reg_threshold};
    end else if (done_wr && hit3) begin
      irth_reg <= irth_w;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  ccm_image_t  image_reg;
  logic [11:0] prechg_ma_reg;
  logic [11:0] term_ma_reg;
  logic [5:0]  hours_reg;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      image_reg     <= '0;
      prechg_ma_reg <= 12'h000;
      term_ma_reg   <= 12'h000;
      hours_reg     <= 6'h00;
    end else begin
      image_reg     <= img;
      prechg_ma_reg <= cur_ma(prechg_reg);
      term_ma_reg   <= cur_ma(term_cur_reg);
      hours_reg     <= tmr_hours(tmr_en_reg, tmr_len_reg, dbl_timer);
    end
  end

  // ----------------------------------------
  // Watchdog refresh
  // ----------------------------------------
  ccm_wdog_refresh #(
    .REFRESH_CYCLES (REFRESH_CYCLES)
  ) u_wdog (
    .sys_clk       (sys_clk),
    .arst_n        (arst_n),
    .wdog_sel      (`CCM_WDOG_SEL_FIXED),
    .refresh_pulse (wdog_refresh)
  );

  // ----------------------------------------
  // Port drive
  // ----------------------------------------
  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign charger_image  = image_reg;
  assign precharge_ma   = prechg_ma_reg;
  assign termination_ma = term_ma_reg;
  assign timer_hours    = hours_reg;

endmodule : ccm_regs

// File: rtl/ccm_defines.svh
// Offsets, field layouts, reset values and timing counts of the charger mirror bank.
// Included by every design file that needs a constant; the package does not include it.
`ifndef CCM_DEFINES_SVH
`define CCM_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define CCM_IDX_PRETERM    8'h78
`define CCM_IDX_VOLTAGE    8'h79
`define CCM_IDX_TERMTIMER  8'h7A
`define CCM_IDX_IRTHERMAL  8'h7B

// ----------------------------------------
// Host-writable bit masks
// ----------------------------------------
`define CCM_WMASK_PRETERM   8'hF0
`define CCM_WMASK_VOLTAGE   8'h02
`define CCM_WMASK_TERMTIMER 8'h4E
`define CCM_WMASK_IRTHERMAL 8'hFF

// ----------------------------------------
// Fixed and reset values
// ----------------------------------------
`define CCM_TERM_EN_FIXED    1'b0
`define CCM_RECHG_FIXED      1'b1
`define CCM_TEMP_ISET_FIXED  1'b0
`define CCM_TERM_STAT_RST    1'b0
`define CCM_WDOG_SEL_FIXED   2'h1
`define CCM_CHARGE_VOLTAGE_RST         6'h00
`define CCM_CUR_STEP_SHIFT   7
`define CCM_CUR_OFFSET_MA    12'h080

// ----------------------------------------
// Timing
// ----------------------------------------
`define CCM_CLK_HZ           64'd250000000
`define CCM_REFRESH_S        64'd15
`define CCM_REFRESH_CYCLES   32'(`CCM_REFRESH_S * `CCM_CLK_HZ)

// ----------------------------------------
// Safety timer lengths in hours
// ----------------------------------------
`define CCM_TMR_H0           6'h05
`define CCM_TMR_H1           6'h08
`define CCM_TMR_H2           6'h0C
`define CCM_TMR_H3           6'h14

`endif

// File: rtl/ccm_pkg.sv
// Types shared by the charger mirror bank.
// Assumes ccm_defines.svh is on the include path.
package ccm_pkg;

  // ----------------------------------------
  // Stored defaults loaded in the first cycle after reset release
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] precharge_current;
    logic [3:0] termination_current;
    logic       fast_charge_entry_threshold;
    logic       timer_enable;
    logic [1:0] fast_charge_timer_length;
    logic [2:0] ir_comp_resistor;
    logic [2:0] ir_comp_clamp;
    logic [1:0] thermal_reg_threshold;
  } ccm_nv_t;

  // ----------------------------------------
  // Byte image of the four registers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] precharge_term_current;
    logic [7:0] charge_voltage_control;
    logic [7:0] termination_timer_control;
    logic [7:0] ir_comp_thermal_control;
  } ccm_image_t;

endpackage : ccm_pkg

// File: rtl/ccm_wdog_refresh.sv
// Periodic refresh pulse for the charger watchdog.
// Free-running on sys_clk; keeps counting in every power mode of the gauge.
`timescale 1ns/100ps
`include "ccm_defines.svh"

module ccm_wdog_refresh
  import ccm_pkg::*;
#(
  parameter logic [31:0] REFRESH_CYCLES = `CCM_REFRESH_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Watchdog select; any nonzero value arms the refresh strobe, the period is fixed
  input  wire logic [1:0] wdog_sel,
  // Refresh strobe
  output logic            refresh_pulse
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        hit;

  // ----------------------------------------
  // Interval counter
  // ----------------------------------------
  assign hit      = (cnt_reg == REFRESH_CYCLES - 32'h1);
  assign cnt_next = hit ? 32'h0 : cnt_reg + 32'h1;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------
  // Refresh pulse, only while the watchdog is armed
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      refresh_pulse <= 1'b0;
    end else begin
      refresh_pulse <= hit && (wdog_sel != 2'h0);
    end
  end

endmodule : ccm_wdog_refresh

// File: tb/ccm_regs_props.sv
// Concurrent checks on the ports of the charger mirror bank.
// Assumes ccm_pkg is compiled first; bound into every ccm_regs instance.
`timescale 1ns/100ps

module ccm_regs_props
  import ccm_pkg::*;
#(
  parameter logic [31:0] REFRESH_CYCLES = 32'd20
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Gauge side
  input wire ccm_nv_t     nv_defaults,
  input wire logic        charge_voltage_load,
  input wire logic [5:0]  charge_voltage_value,
  input wire logic        vin_reg_pin,
  input wire logic        iin_reg_pin,
  input wire logic        therm_reg_pin,
  // Charger settings
  input wire ccm_image_t  charger_image,
  input wire logic [11:0] precharge_ma,
  input wire logic [11:0] termination_ma,
  input wire logic [5:0]  timer_hours,
  input wire logic        wdog_refresh
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [1:0]  up_reg;
  logic [31:0] gap_reg;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) gap_reg <= 32'h0;
    else if (wdog_refresh) gap_reg <= 32'h1;
    else if (gap_reg != 32'h0) gap_reg <= gap_reg + 32'h1;
  end

  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_load;
    charge_voltage_load ##1 !charge_voltage_load;
  endsequence

  a_ready_next: assert property (s_access |=> pready)
    else $error("pready missing after access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready |->
    (pslverr == !(paddr inside {12'h1E0, 12'h1E4, 12'h1E8, 12'h1EC})))
    else $error("pslverr wrong for address");
  a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_fixed_bits: assert property (up_reg == 2'h3 |-> charger_image[16] && !charger_image[15]
    && charger_image[13:12] == 2'h1 && !charger_image[8])
    else $error("fixed bit changed");
  a_pre_ma: assert property (up_reg == 2'h3 |->
    precharge_ma == {1'b0, charger_image[31:28], 7'h00} + 12'h080)
    else $error("precharge current wrong");
  a_term_ma: assert property (up_reg == 2'h3 |->
    termination_ma == {1'b0, charger_image[27:24], 7'h00} + 12'h080)
    else $error("termination current wrong");
  a_timer_off: assert property (up_reg == 2'h3 && !charger_image[11] |-> timer_hours == 6'h00)
    else $error("timer hours while disabled");
  a_refresh_gap: assert property (wdog_refresh && gap_reg != 32'h0 |->
    gap_reg == REFRESH_CYCLES)
    else $error("refresh period wrong");
  a_refresh_late: assert property (gap_reg <= REFRESH_CYCLES)
    else $error("refresh overdue");
  a_charge_voltage_load: assert property (s_load |=> charger_image[23:18] == $past(charge_voltage_value, 2))
    else $error("charge voltage not loaded");
endmodule : ccm_regs_props

bind ccm_regs ccm_regs_props #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_props (
  .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .nv_defaults(nv_defaults), .charge_voltage_load(charge_voltage_load), .charge_voltage_value(charge_voltage_value),
  .vin_reg_pin(vin_reg_pin), .iin_reg_pin(iin_reg_pin), .therm_reg_pin(therm_reg_pin),
  .charger_image(charger_image), .precharge_ma(precharge_ma),
  .termination_ma(termination_ma), .timer_hours(timer_hours), .wdog_refresh(wdog_refresh));

// File: tb/ccm_charger_model.sv
// Charger side model: regulation flags on request, counts refresh strobes.
// Assumes the bench requests regulation right after a clock edge.
`timescale 1ns/100ps

module ccm_charger_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Requests and strobe
  input  wire logic [2:0] reg_req,
  input  wire logic       wdog_refresh,
  // Regulation pins
  output logic            vin_reg_pin,
  output logic            iin_reg_pin,
  output logic            therm_reg_pin,
  // Strobe count
  output int              refresh_cnt
);
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) {vin_reg_pin, iin_reg_pin, therm_reg_pin} <= 3'h0;
    else {vin_reg_pin, iin_reg_pin, therm_reg_pin} <= reg_req;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) refresh_cnt <= 0;
    else if (wdog_refresh === 1'b1) refresh_cnt <= refresh_cnt + 1;
  end
endmodule : ccm_charger_model

// File: tb/ccm_regs_tb.sv
// Self-checking bench for the charger mirror bank over APB.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/100ps

module ccm_regs_tb;
  import ccm_pkg::*;
  localparam logic [31:0] REF = 32'd20;
  localparam logic [7:0]  WM [4] = '{8'hF0, 8'h02, 8'h4E, 8'hFF};
  localparam logic [5:0]  HRS [4] = '{6'h05, 6'h08, 6'h0C, 6'h14};
  logic        sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        charge_voltage_load = 1'b0, pready, pslverr, vin_p, iin_p, therm_p, wdog_refresh;
  logic [11:0] paddr = 12'h000, precharge_ma, termination_ma;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [5:0]  charge_voltage_value = 6'h00, timer_hours;
  logic [2:0]  reg_req = 3'h0;
  logic [15:0] lfsr = 16'hDC04;
  logic [7:0]  exp_r [4];
  logic [9:0]  q [$];
  logic [9:0]  note;
  ccm_nv_t     nv_defaults;
  ccm_image_t  charger_image;
  int          refresh_cnt, c0, n_errors = 0, checks = 0;

  always #2 sys_clk = ~sys_clk;

  ccm_regs #(.REFRESH_CYCLES(REF)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nv_defaults(nv_defaults), .charge_voltage_load(charge_voltage_load),
    .charge_voltage_value(charge_voltage_value), .vin_reg_pin(vin_p), .iin_reg_pin(iin_p),
    .therm_reg_pin(therm_p), .charger_image(charger_image), .precharge_ma(precharge_ma),
    .termination_ma(termination_ma), .timer_hours(timer_hours), .wdog_refresh(wdog_refresh));
  ccm_charger_model u_chg (.sys_clk(sys_clk), .arst_n(arst_n), .reg_req(reg_req),
    .wdog_refresh(wdog_refresh), .vin_reg_pin(vin_p), .iin_reg_pin(iin_p),
    .therm_reg_pin(therm_p), .refresh_cnt(refresh_cnt));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
    checks++;
    if (got !== exp_v) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp_v);
    end
  endtask : chk

  task automatic chk_bus(input logic [9:0] exp_n);
    chk({31'h0, pslverr}, {31'h0, exp_n[8]});
    if (exp_n[9]) chk(prdata, {24'h0, exp_n[7:0]});
  endtask : chk_bus

  task automatic finish_test;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    logic       err;
    logic [1:0] i;
    err = !(a inside {12'h1E0, 12'h1E4, 12'h1E8, 12'h1EC});
    i = a[3:2];
    if (wr && !err) exp_r[i] = (exp_r[i] & ~WM[i]) | (d & WM[i]);
    q.push_back({!wr, err, err ? 8'h00 : exp_r[i]});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {lfsr, lfsr[7:0], d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
  endtask : apb

  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : idle

  task automatic rd_all;
    for (int k = 0; k < 4; k++) apb(1'b0, 12'h1E0 + 12'(4 * k), 8'h00);
    idle();
    chk(charger_image, {exp_r[0], exp_r[1], exp_r[2], exp_r[3]});
    chk(32'({1'b0, exp_r[0][7:4], 7'h00} + 12'h080), 32'(precharge_ma));
    chk(32'({1'b0, exp_r[0][3:0], 7'h00} + 12'h080), 32'(termination_ma));
  endtask : rd_all

  // ----------------------------------------
  // Bus result monitor
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (pready === 1'b1) begin
      note = q.pop_front();
      chk_bus(note);
    end
  end

  initial begin
    #40000;
    n_errors++;
    finish_test();
  end

  task automatic reset_dut;
    ccm_nv_t nv;
    nv = {lfsr[3:0], lfsr_next(lfsr)};
    lfsr = lfsr_next(lfsr);
    arst_n <= 1'b0;
    nv_defaults <= nv;
    exp_r[0] = {nv.precharge_current, nv.termination_current};
    exp_r[1] = {6'h00, nv.fast_charge_entry_threshold, 1'b1};
    exp_r[2] = {4'h1, nv.timer_enable, nv.fast_charge_timer_length, 1'b0};
    exp_r[3] = {nv.ir_comp_resistor, nv.ir_comp_clamp, nv.thermal_reg_threshold};
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_all();
  endtask : reset_dut

  initial begin
    reset_dut();
    for (int n = 0; n < 8; n++) begin
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, 12'h1E0 + 12'(4 * k), n == 0 ? 8'hFF : n == 1 ? 8'h00 : lfsr[7:0]);
        lfsr = lfsr_next(lfsr);
      end
      rd_all();
    end
    apb(1'b1, 12'h1F0, 8'h5A);
    apb(1'b0, 12'h1F0, 8'h00);
    apb(1'b1, 12'h1E2, 8'hFF);
    apb(1'b0, 12'h1DC, 8'h00);
    rd_all();
    @(posedge sys_clk);
    charge_voltage_load <= 1'b1;
    charge_voltage_value <= lfsr[5:0];
    exp_r[1][7:2] = lfsr[5:0];
    @(posedge sys_clk);
    charge_voltage_load <= 1'b0;
    @(posedge sys_clk);
    rd_all();
    for (int l = 0; l < 4; l++) begin
      apb(1'b1, 12'h1E8, {4'h0, 1'b1, 2'(l), 1'b0});
      idle();
      repeat (3) @(posedge sys_clk);
      chk(32'(timer_hours), 32'(HRS[l]));
      reg_req <= 3'(1 << (l % 3));
      repeat (5) @(posedge sys_clk);
      chk(32'(timer_hours), 32'({HRS[l], 1'b0}));
      reg_req <= 3'h0;
      repeat (5) @(posedge sys_clk);
    end
    apb(1'b1, 12'h1E8, 8'h06);
    rd_all();
    repeat (3) @(posedge sys_clk);
    chk(32'(timer_hours), 32'h0);
    reset_dut();
    c0 = refresh_cnt;
    repeat (200) @(posedge sys_clk);
    chk(32'(refresh_cnt - c0), 32'(200 / REF));
    finish_test();
  end
endmodule : ccm_regs_tb
